// >>> common/adcspi_pkg.sv
/*
 Constants, field positions and types of the converter serial port.
 Assumes one 25 MHz system clock; serial pins are sampled on it.
*/
package adcspi_pkg;
	// System clock and serial clock rates
	localparam int MCLK_HZ = 25000000;
	localparam int EXT_SCLK_MAX_HZ = 5000000;
	// Fewest system clocks per external serial clock period
	localparam int EXT_SCLK_MIN_CYC = (MCLK_HZ + EXT_SCLK_MAX_HZ - 1) / EXT_SCLK_MAX_HZ;
	localparam int SELF_DIV = 8;
	localparam logic [1:0] DIV_HALF_LAST = 2'(SELF_DIV / 2 - 1);

	// Instruction byte fields
	localparam int IB_RW = 7;
	localparam int IB_CNT_HI = 6;
	localparam int IB_CNT_LO = 5;
	localparam int IB_FSC = 4;
	localparam int IB_RS_HI = 3;
	localparam int IB_RS_LO = 2;
	localparam int IB_SB_HI = 1;
	localparam int IB_SB_LO = 0;

	// Control register fields
	localparam int CTL_BIDIR = 0;
	localparam int CTL_LSB_FIRST = 1;
	localparam int CTL_BYTE_ASC = 2;

	// Register selects
	localparam logic [1:0] RS_RESULT = 2'h0;
	localparam logic [1:0] RS_CTRL = 2'h1;
	localparam logic [1:0] RS_OFFS = 2'h2;
	localparam logic [1:0] RS_FULL = 2'h3;

	// Values after reset, and the last bit index
	localparam logic [23:0] CTRL_RST = 24'h000000;
	localparam logic [23:0] CAL_RST = 24'h000000;
	localparam logic [23:0] RESULT_RST = 24'h000000;
	localparam logic [1:0] DIV_RST = 2'h0;
	localparam logic [2:0] BIT_RST = 3'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;

	typedef enum logic {adcspi_ph_instr, adcspi_ph_data} adcspi_phase_e;
endpackage

// >>> common/adcspi_clk_if.sv
/*
 Serial clock events passed from the clock unit to the port engine.
 Assumes both ends run on the system clock.
*/
`timescale 1ns/1ps
interface adcspi_clk_if;
	logic cs_n;
	logic mode;
	logic rise;
	logic fall;
	modport gen (input cs_n, input mode, output rise, output fall);
	modport eng (output cs_n, output mode, input rise, input fall);
endinterface

// >>> logic/adcspi_clkgen.sv
/*
 Serial clock unit: edge detector for a host clock, or divider for self clocking.
 Assumes the serial clock pin is synchronous to mclk.
*/
`timescale 1ns/1ps
module adcspi_clkgen (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Events
	adcspi_clk_if.gen sif,
	// Serial clock pin
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe_n
);
	logic prev_q;
	logic [1:0] div_q;
	logic tick;
	logic ext_rise;
	logic ext_fall;

	assign tick = sif.mode && !sif.cs_n && (div_q == adcspi_pkg::DIV_HALF_LAST);
	assign ext_rise = sclk_in && !prev_q;
	assign ext_fall = !sclk_in && prev_q;
	// Events only while selected, so the engine freezes otherwise
	assign sif.rise = !sif.cs_n && (sif.mode ? (tick && !sclk_out) : ext_rise);
	assign sif.fall = !sif.cs_n && (sif.mode ? (tick && sclk_out) : ext_fall);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			prev_q <= 1'b1;
		end else begin
			prev_q <= sclk_in;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			div_q <= adcspi_pkg::DIV_RST;
			sclk_out <= 1'b1;
		end else if (!sif.mode || sif.cs_n) begin
			div_q <= adcspi_pkg::DIV_RST;
			sclk_out <= 1'b1;
		end else begin
			div_q <= div_q + 2'h1;
			if (tick) begin
				sclk_out <= !sclk_out;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sclk_oe_n <= 1'b1;
		end else begin
			sclk_oe_n <= !sif.mode;
		end
	end

	property p_self_half;
		@(posedge mclk) disable iff (!nrst)
		($fell(sclk_out) && sif.mode) |-> (!sclk_out)[*4];
	endproperty
	a_self_half: assert property (p_self_half) else $error("self clock low phase short");

	property p_pin_dir;
		@(posedge mclk) disable iff (!nrst)
		##1 (sclk_oe_n == !$past(sif.mode));
	endproperty
	a_pin_dir: assert property (p_pin_dir) else $error("serial clock pin direction wrong");
endmodule

// >>> logic/adcspi_port.sv
/*
 Converter serial port: instruction decode, register file, shifting and ready flag.
 Assumes pins synchronous to mclk and a host keeping byte framing.
*/
// Summary of operation
// - In bidirectional setting the separate output line stays undriven.
// - Instruction and write data always enter on the shared data line.
// - Shared line drives read data only when control selects bidirectional.
// - Self clocking drives the clock pin at oscillator divided by 8.
// - Chip select high puts both data outputs in high impedance.
// - Chip select high freezes a cycle, which resumes where it stopped.
// - Ready flag goes low when a new result is loaded.
// - Ready flag returns high after the last byte of a result register read cycle, unless a new result loads in that cycle.
// - Mode pin 1 selects self clocking, 0 selects host clocking.
// - Each cycle is an instruction byte, then its data phase.
// - Data phase moves one up to several consecutive bytes.
// - Control bits 2 and 1 set byte direction and bit order.
// - Both bits clear: descending bytes, most significant bit first.
// - Both bits set: ascending bytes, least significant bit first.
// - After a cycle the next byte is taken as an instruction.
// - Instruction byte carries direction, count, register and start byte.
// - Bit 7 direction, bits 3:2 register, bits 1:0 start byte.
// - Bits 6:5 give one to four data bytes.
// - Input data sampled on serial clock rising edge.
// - Read bits launched on serial clock falling edge.
`timescale 1ns/1ps
module adcspi_port (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Control pins
	input wire logic cs_n,
	input wire logic mode,
	// Serial clock pin
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe_n,
	// Shared data line
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe_n,
	// Separate output line
	output logic serial_out_line,
	output logic serial_out_line_oe_n,
	// Conversion result
	input wire logic [23:0] result_word,
	input wire logic result_load,
	output logic result_ready_flag_n,
	// Register contents
	output logic [23:0] control_reg,
	output logic [23:0] offset_cal,
	output logic [23:0] pos_cal,
	output logic [23:0] neg_cal
);
	adcspi_clk_if sif ();

	adcspi_pkg::adcspi_phase_e phase_q;
	logic rw_q;
	logic fsc_q;
	logic [1:0] cnt_q;
	logic [1:0] rsel_q;
	logic [1:0] ptr_q;
	logic [2:0] bit_q;
	logic [7:0] shreg_q;
	logic [23:0] result_q;
	logic out_q;
	logic lsb_first;
	logic asc;
	logic bidir;
	logic in_data;
	logic byte_done;
	logic last_byte;
	logic read_done;
	logic read_act;
	logic [7:0] rx_byte;
	logic [23:0] cur_word;
	logic [7:0] cur_byte;
	logic [2:0] bidx;
	logic [1:0] ptr_next;

	assign sif.cs_n = cs_n;
	assign sif.mode = mode;

	adcspi_clkgen u_clkgen (
		.mclk(mclk),
		.nrst(nrst),
		.sif(sif.gen),
		.sclk_in(sclk_in),
		.sclk_out(sclk_out),
		.sclk_oe_n(sclk_oe_n)
	);

	assign lsb_first = control_reg[adcspi_pkg::CTL_LSB_FIRST];
	assign asc = control_reg[adcspi_pkg::CTL_BYTE_ASC];
	assign bidir = control_reg[adcspi_pkg::CTL_BIDIR];
	assign in_data = (phase_q == adcspi_pkg::adcspi_ph_data);
	assign byte_done = sif.rise && (bit_q == adcspi_pkg::BIT_LAST);
	assign last_byte = (cnt_q == 2'h0);
	assign read_done = in_data && byte_done && last_byte && !rw_q
		&& (rsel_q == adcspi_pkg::RS_RESULT);
	assign read_act = in_data && !rw_q && !cs_n;
	// Instruction always most significant bit first
	assign rx_byte = (in_data && lsb_first) ? {sdio_in, shreg_q[7:1]}
		: {shreg_q[6:0], sdio_in};
	assign ptr_next = asc ? ptr_q + 2'h1 : ptr_q - 2'h1;
	assign bidx = lsb_first ? bit_q : adcspi_pkg::BIT_LAST - bit_q;

	always_comb begin
		case (rsel_q)
			adcspi_pkg::RS_RESULT: cur_word = result_q;
			adcspi_pkg::RS_CTRL: cur_word = control_reg;
			adcspi_pkg::RS_OFFS: cur_word = offset_cal;
			adcspi_pkg::RS_FULL: cur_word = fsc_q ? neg_cal : pos_cal;
			default: cur_word = result_q;
		endcase
	end

	always_comb begin
		case (ptr_q)
			2'h0: cur_byte = cur_word[7:0];
			2'h1: cur_byte = cur_word[15:8];
			2'h2: cur_byte = cur_word[23:16];
			default: cur_byte = 8'h00;
		endcase
	end

	// Byte slot replacement; the unmapped fourth slot is dropped
	function automatic logic [23:0] put_byte(input logic [23:0] w, input logic [1:0] p,
		input logic [7:0] b);
		logic [23:0] r;
		r = w;
		case (p)
			2'h0: r[7:0] = b;
			2'h1: r[15:8] = b;
			2'h2: r[23:16] = b;
			default: r = w;
		endcase
		return r;
	endfunction

	// Bit shifting and phase sequencing
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			shreg_q <= 8'h00;
			bit_q <= adcspi_pkg::BIT_RST;
		end else if (sif.rise) begin
			shreg_q <= rx_byte;
			bit_q <= bit_q + 3'h1;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			phase_q <= adcspi_pkg::adcspi_ph_instr;
			rw_q <= 1'b0;
			fsc_q <= 1'b0;
			cnt_q <= 2'h0;
			rsel_q <= adcspi_pkg::RS_RESULT;
			ptr_q <= 2'h0;
		end else if (byte_done) begin
			case (phase_q)
				adcspi_pkg::adcspi_ph_instr: begin
					phase_q <= adcspi_pkg::adcspi_ph_data;
					rw_q <= rx_byte[adcspi_pkg::IB_RW];
					cnt_q <= rx_byte[adcspi_pkg::IB_CNT_HI:adcspi_pkg::IB_CNT_LO];
					fsc_q <= rx_byte[adcspi_pkg::IB_FSC];
					rsel_q <= rx_byte[adcspi_pkg::IB_RS_HI:adcspi_pkg::IB_RS_LO];
					ptr_q <= rx_byte[adcspi_pkg::IB_SB_HI:adcspi_pkg::IB_SB_LO];
				end
				adcspi_pkg::adcspi_ph_data: begin
					if (last_byte) begin
						phase_q <= adcspi_pkg::adcspi_ph_instr;
					end else begin
						cnt_q <= cnt_q - 2'h1;
						ptr_q <= ptr_next;
					end
				end
				default: phase_q <= adcspi_pkg::adcspi_ph_instr;
			endcase
		end
	end

	// Register writes at the end of each data byte
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			control_reg <= adcspi_pkg::CTRL_RST;
			offset_cal <= adcspi_pkg::CAL_RST;
			pos_cal <= adcspi_pkg::CAL_RST;
			neg_cal <= adcspi_pkg::CAL_RST;
		end else if (byte_done && in_data && rw_q) begin
			case (rsel_q)
				adcspi_pkg::RS_CTRL: control_reg <= put_byte(control_reg, ptr_q, rx_byte);
				adcspi_pkg::RS_OFFS: offset_cal <= put_byte(offset_cal, ptr_q, rx_byte);
				adcspi_pkg::RS_FULL: begin
					if (fsc_q) begin
						neg_cal <= put_byte(neg_cal, ptr_q, rx_byte);
					end else begin
						pos_cal <= put_byte(pos_cal, ptr_q, rx_byte);
					end
				end
				default: control_reg <= control_reg;
			endcase
		end
	end

	// Result register and ready flag; a new result wins over a read finishing
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			result_q <= adcspi_pkg::RESULT_RST;
			result_ready_flag_n <= 1'b1;
		end else if (result_load) begin
			result_q <= result_word;
			result_ready_flag_n <= 1'b0;
		end else if (read_done) begin
			result_ready_flag_n <= 1'b1;
		end
	end

	// Read data launch and output enables
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			out_q <= 1'b0;
		end else if (sif.fall) begin
			out_q <= cur_byte[bidx];
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sdio_oe_n <= 1'b1;
			serial_out_line_oe_n <= 1'b1;
		end else begin
			sdio_oe_n <= !(read_act && bidir);
			serial_out_line_oe_n <= !(read_act && !bidir);
		end
	end

	assign sdio_out = out_q;
	assign serial_out_line = out_q;

	property p_cs_float;
		@(posedge mclk) disable iff (!nrst)
		cs_n |=> (sdio_oe_n && serial_out_line_oe_n);
	endproperty
	a_cs_float: assert property (p_cs_float) else $error("outputs driven while deselected");

	property p_out_line_off;
		@(posedge mclk) disable iff (!nrst)
		bidir |=> serial_out_line_oe_n;
	endproperty
	a_out_line_off: assert property (p_out_line_off) else $error("output line driven in shared mode");

	property p_sdio_only_bidir;
		@(posedge mclk) disable iff (!nrst)
		!bidir |=> sdio_oe_n;
	endproperty
	a_sdio_only_bidir: assert property (p_sdio_only_bidir) else $error("shared line driven");

	property p_freeze;
		@(posedge mclk) disable iff (!nrst)
		cs_n |=> ($stable(bit_q) && $stable(phase_q) && $stable(ptr_q));
	endproperty
	a_freeze: assert property (p_freeze) else $error("cycle advanced while deselected");

	property p_ready_low;
		@(posedge mclk) disable iff (!nrst)
		result_load |=> (!result_ready_flag_n && (result_q == $past(result_word)));
	endproperty
	a_ready_low: assert property (p_ready_low) else $error("ready flag not set on load");

	property p_ready_high;
		@(posedge mclk) disable iff (!nrst)
		(read_done && !result_load) |=> result_ready_flag_n;
	endproperty
	a_ready_high: assert property (p_ready_high) else $error("ready flag not cleared");

	property p_idle_after;
		@(posedge mclk) disable iff (!nrst)
		(in_data && byte_done && last_byte) |=> (phase_q == adcspi_pkg::adcspi_ph_instr);
	endproperty
	a_idle_after: assert property (p_idle_after) else $error("no return to instruction");

	property p_ptr_step;
		@(posedge mclk) disable iff (!nrst)
		(in_data && byte_done && !last_byte) |=> (ptr_q == ($past(asc) ? $past(ptr_q) + 2'h1
			: $past(ptr_q) - 2'h1)) && (cnt_q == $past(cnt_q) - 2'h1);
	endproperty
	a_ptr_step: assert property (p_ptr_step) else $error("byte pointer step wrong");

	property p_sample_rise;
		@(posedge mclk) disable iff (!nrst)
		(sif.rise && !(in_data && lsb_first)) |=> (shreg_q[0] == $past(sdio_in));
	endproperty
	a_sample_rise: assert property (p_sample_rise) else $error("input bit not sampled");
endmodule

// >>> testbench/adcspi_host_model.sv
/*
 Host serial master model: clocks bytes through the port and samples read bits.
 Assumes the bench resolves the pins and shares the system clock with the port.
*/
`timescale 1ns/1ps
module adcspi_host_model (
	// Clock
	input wire logic mclk,
	// Serial pins
	input wire logic self_clk,
	input wire logic sclk_pin,
	input wire logic sdio_pin,
	input wire logic so_pin,
	output logic sclk_drv,
	output logic sdio_drv,
	output logic cs_n
);
	initial begin
		sclk_drv = 1'b1;
		sdio_drv = 1'b1;
		cs_n = 1'b1;
	end

	// Half period of 4 system clocks keeps the host clock under 5 MHz
	task automatic edge_to(input logic lvl);
		int n;
		n = 0;
		if (!self_clk) begin
			repeat (4) @(negedge mclk);
			sclk_drv = lvl;
		end else begin
			do begin
				@(negedge mclk);
				n++;
			end while (sclk_pin !== lvl && n < 40);
			if (n == 40) begin
				adcspi_port_tb.n_errors++;
				adcspi_port_tb.test_done();
			end
		end
	endtask

	task automatic xfer(input logic [7:0] tx, input logic lsb, input logic bidir,
		output logic [7:0] rx);
		for (int i = 0; i < 8; i++) begin
			edge_to(1'b0);
			sdio_drv = lsb ? tx[i] : tx[7 - i];
			edge_to(1'b1);
			rx[lsb ? i : 7 - i] = bidir ? sdio_pin : so_pin;
		end
	endtask
endmodule

// >>> testbench/adcspi_port_tb.sv
/*
 Self-checking bench of the converter serial port, host and self clocked.
 Assumes the design package and the host model are compiled first.
*/
`timescale 1ns/1ps
module adcspi_port_tb;
	logic mclk, nrst, mode, result_load, byte_asc, lsb, bidir, sclk_q;
	logic [23:0] result_word;
	int n_errors, n_tests, cnt, per;
	wire logic sclk_drv, sdio_drv, cs_n, sclk_out, sclk_oe_n, sdio_out, sdio_oe_n;
	wire logic so, so_oe_n, flag_n;
	wire logic [23:0] ctrl, offs, posc, negc;
	wire logic sclk_w = sclk_oe_n ? sclk_drv : sclk_out;
	wire logic sdio_w = sdio_oe_n ? sdio_drv : sdio_out;
	// Released output line shows the inverse of its last bit
	wire logic so_w = so ^ so_oe_n;

	adcspi_port i_dut (.mclk(mclk), .nrst(nrst), .cs_n(cs_n), .mode(mode), .sclk_in(sclk_w),
		.sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .sdio_in(sdio_w), .sdio_out(sdio_out),
		.sdio_oe_n(sdio_oe_n), .serial_out_line(so), .serial_out_line_oe_n(so_oe_n),
		.result_word(result_word), .result_load(result_load), .result_ready_flag_n(flag_n),
		.control_reg(ctrl), .offset_cal(offs), .pos_cal(posc), .neg_cal(negc));
	adcspi_host_model i_host (.mclk(mclk), .self_clk(mode), .sclk_pin(sclk_w),
		.sdio_pin(sdio_w), .so_pin(so_w), .sclk_drv(sclk_drv), .sdio_drv(sdio_drv),
		.cs_n(cs_n));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Rise to rise spacing of the self clock
	always @(posedge mclk) begin
		sclk_q <= sclk_out;
		cnt <= (sclk_out && !sclk_q) ? 1 : cnt + 1;
		if (sclk_out && !sclk_q)
			per <= cnt;
	end

	task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic test_done();
		if (n_errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// One whole cycle; the bench keeps byte framing itself
	task automatic cyc(input logic wr, input logic [2:0] sel, input logic [1:0] sb, input int n,
		input logic [23:0] w, output logic [23:0] r);
		logic [7:0] b;
		logic [1:0] p;
		p = sb;
		r = w;
		@(negedge mclk);
		i_host.cs_n = 1'b0;
		i_host.xfer({wr, 2'(n - 1), sel, sb}, 1'b0, 1'b0, b);
		for (int k = 0; k < n; k++) begin
			i_host.xfer(w[8 * p +: 8], lsb, bidir, b);
			r[8 * p +: 8] = b;
			p = byte_asc ? p + 2'h1 : p - 2'h1;
			if (k == 0 && !wr) begin
				chk("oe_sel", {22'h0, sdio_oe_n, so_oe_n}, {22'h0, !bidir, bidir});
			end
			if (k == 0 && !wr && !mode) begin
				// Suspend between bytes, clock keeps toggling
				repeat (2) @(negedge mclk);
				i_host.cs_n = 1'b1;
				i_host.edge_to(1'b0);
				i_host.edge_to(1'b1);
				repeat (2) @(negedge mclk);
				chk("oe_off", {22'h0, sdio_oe_n, so_oe_n}, 24'h3);
				i_host.cs_n = 1'b0;
			end
		end
		repeat (2) @(negedge mclk);
		i_host.cs_n = 1'b1;
	endtask

	initial begin
		logic [23:0] w, r, e;
		logic [2:0] sel;
		nrst = 1'b0;
		mode = 1'b0;
		result_load = 1'b0;
		result_word = 24'h0;
		byte_asc = 1'b0;
		lsb = 1'b0;
		bidir = 1'b0;
		n_errors = 0;
		n_tests = 0;
		cnt = 0;
		per = 0;
		sclk_q = 1'b1;
		void'($urandom(32'h320C56F6));
		repeat (3) @(negedge mclk);
		nrst = 1'b1;
		chk("reset", {ctrl[7:0], 13'h0, sdio_oe_n, so_oe_n, flag_n}, 24'h7);
		for (int m = 0; m < 16; m++) begin
			mode = m[3];
			w = 24'($urandom);
			w[2:0] = m[2:0];
			cyc(1'b1, 3'h1, 2'h0, 1, w, r);
			chk("ctrl", {16'h0, ctrl[7:0]}, {16'h0, w[7:0]});
			byte_asc = w[2];
			lsb = w[1];
			bidir = w[adcspi_pkg::CTL_BIDIR];
			// Two byte control read from byte 1; unread byte keeps its fill
			e = {16'h0, w[7:0]};
			cyc(1'b0, 3'h1, 2'h1, 2, ~e, r);
			chk("ctrl_rd", r, byte_asc ? {e[23:8], ~e[7:0]} : {~e[23:16], e[15:0]});
			sel = (m % 3 == 0) ? 3'h2 : (m % 3 == 1) ? 3'h3 : 3'h7;
			w = 24'($urandom);
			cyc(1'b1, sel, byte_asc ? 2'h0 : 2'h2, 3, w, r);
			chk("cal", (m % 3 == 0) ? offs : (m % 3 == 1) ? posc : negc, w);
			cyc(1'b0, sel, byte_asc ? 2'h0 : 2'h2, 3, ~w, r);
			chk("cal_rd", r, w);
			w = 24'($urandom);
			@(negedge mclk);
			result_word = w;
			result_load = 1'b1;
			@(negedge mclk);
			result_load = 1'b0;
			repeat (2) @(negedge mclk);
			chk("flag_set", {23'h0, flag_n}, 24'h0);
			cyc(1'b0, 3'h0, byte_asc ? 2'h0 : 2'h2, 3, 24'h0, r);
			chk("result", r, w);
			chk("flag_clr", {23'h0, flag_n}, 24'h1);
			chk("sclk_oe", {23'h0, sclk_oe_n}, {23'h0, !mode});
		end
		chk("self_period", 24'(per), 24'(adcspi_pkg::SELF_DIV));
		test_done();
	end
endmodule
